/* include/stp_cfg.svh */
`ifndef STP_CFG_SVH
`define STP_CFG_SVH

// register byte offsets
`define STP_CTRL 8'h00
`define STP_STATUS 8'h04
`define STP_TEL_SLF 8'h08
`define STP_TEL_RLC 8'h0C
`define STP_TEL_SIG 8'h10
`define STP_TI 8'h14
`define STP_SLF_INFO 8'h18
`define STP_ENTRY_SEL 8'h1C
`define STP_ENTRY_CFG 8'h20
`define STP_ENTRY_LRLC 8'h24
`define STP_ENTRY_RRLC 8'h28
`define STP_KEY_TX 8'h30
`define STP_KEY_RX 8'h40
`define STP_DATA_IN 8'h50
`define STP_DATA_OUT 8'h60
`define STP_SIG_OUT 8'h70

// control and entry config bit positions
`define STP_CTRL_TX 0
`define STP_CTRL_RX 1
`define STP_CTRL_BCAST 2
`define STP_ENTRY_VALID_BIT 8

// security level byte fields
`define STP_MODE_HI 7
`define STP_MODE_LO 5
`define STP_SIZE_HI 4
`define STP_SIZE_LO 3
`define STP_CIPH_HI 2
`define STP_CIPH_LO 0
`define STP_SLF_COMMON_A 8'h4B
`define STP_SLF_COMMON_B 8'hAB
`define STP_SLF_COMMON_C 8'hF3

// teach-in info byte fields
`define STP_TI_IDX_HI 7
`define STP_TI_IDX_LO 6
`define STP_TI_CNT_HI 5
`define STP_TI_CNT_LO 4
`define STP_TI_PSK 3
`define STP_TI_TYPE 2
`define STP_TI_INFO_HI 1
`define STP_TI_INFO_LO 0

// cipher engine
`define STP_AES_ROUNDS 4'hA
`define STP_CMAC_RB 8'h87
`define STP_RCON_INIT 8'h01

`endif

/* include/stp_pkg.sv */
package stp_pkg;

  typedef enum logic [5:0] {
    STP_IDLE = 6'b000001,
    STP_SUBKEY = 6'b000010,
    STP_KSTREAM = 6'b000100,
    STP_MAC = 6'b001000,
    STP_FINISH = 6'b010000,
    STP_DONE = 6'b100000
  } stp_state_t;

  typedef enum logic [2:0] {
    STP_RLC_NONE = 3'h0,
    STP_RLC_16_IMPL = 3'h2,
    STP_RLC_24 = 3'h5,
    STP_RLC_32_24 = 3'h6,
    STP_RLC_32 = 3'h7
  } stp_rolling_code_mode_field_t;

  typedef enum logic [1:0] {
    STP_SIG_NONE = 2'h0,
    STP_SIG_24 = 2'h1,
    STP_SIG_32 = 2'h2,
    STP_SIG_RES = 2'h3
  } stp_sig_size_t;

  typedef enum logic [2:0] {
    STP_CIPH_PLAIN = 3'h0,
    STP_CIPH_VARIANT_AES_MODE = 3'h3,
    STP_CIPH_CBC = 3'h4
  } stp_cipher_t;

  typedef struct packed {
    logic [2:0] rolling_code_mode_field;
    logic [1:0] signature_size_field;
    logic [2:0] cipher_select_field;
  } stp_slf_t;

  typedef struct packed {
    logic slf_mismatch;
    logic unsupported;
    logic passthrough;
    logic replay;
    logic auth_fail;
    logic auth_ok;
    logic done;
    logic busy;
  } stp_status_t;

endpackage

/* src/stp_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`include "stp_cfg.svh"

module stp_engine
  import stp_pkg::*;
#(
  parameter int N_DEV = 4,
  parameter logic [127:0] IV_BASE = 128'h0
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int IW = (N_DEV > 1) ? $clog2(N_DEV) : 1;

  // link storage, one slot per remote device; keys and rolling codes kept per direction
  logic [127:0] key_tx [N_DEV];
  logic [127:0] key_rx [N_DEV];
  logic [31:0] local_tx_rolling_code [N_DEV];
  logic [31:0] remote_rx_rolling_code [N_DEV];
  logic [7:0] entry_slf [N_DEV];
  logic entry_valid [N_DEV];

  logic [IW-1:0] entry_sel;
  logic [7:0] tel_slf;
  logic [31:0] tel_rlc;
  logic [31:0] tel_sig;
  logic [7:0] teach_in_info_byte;
  logic [127:0] data_in;
  logic [127:0] data_out;
  logic [31:0] sig_out;
  stp_status_t status;
  stp_state_t state;

  // job context latched at start
  logic job_rx;
  logic [IW-1:0] job_dev;
  logic [127:0] job_key;
  logic [31:0] job_rlc;
  stp_slf_t job_slf;
  logic [127:0] subkey;
  logic [127:0] plain;

  // cipher core
  logic [127:0] aes_st;
  logic [127:0] aes_rk;
  logic [7:0] aes_rc;
  logic [3:0] aes_rnd;
  logic aes_run;
  logic aes_last;

  logic wr_en;
  logic rd_setup;
  logic [127:0] next_rk;
  logic [127:0] next_st;
  stp_slf_t slf_dec;
  logic start_tx;
  logic start_rx;
  logic [127:0] mac_in;
  logic [31:0] mac_sig;
  logic sig_match;
  logic ti_first, ti_psk, ti_switch, ti_bidir, ti_rocker_b;
  logic [1:0] ti_cnt;

  function automatic logic [7:0] xt(input logic [7:0] a);
    xt = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xt(x);
    end
    gmul = p;
  endfunction

  // s-box from field inverse (a^254) and affine map, avoids a 256-entry table
  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] p;
    logic [7:0] r;
    logic [7:0] s;
    p = a;
    r = 8'h01;
    for (int i = 1; i < 8; i++) begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    s = r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]}
        ^ {r[3:0], r[7:4]} ^ 8'h63;
    sbox = s;
  endfunction

  function automatic logic [127:0] key_step(input logic [127:0] k,
                                            input logic [7:0] rc);
    logic [31:0] t;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    t = {sbox(k[23:16]) ^ rc, sbox(k[15:8]), sbox(k[7:0]), sbox(k[31:24])};
    w0 = k[127:96] ^ t;
    w1 = k[95:64] ^ w0;
    w2 = k[63:32] ^ w1;
    w3 = k[31:0] ^ w2;
    key_step = {w0, w1, w2, w3};
  endfunction

  function automatic logic [127:0] aes_round(input logic [127:0] s,
                                             input logic [127:0] k,
                                             input logic fin);
    logic [7:0] b [16];
    logic [7:0] m [16];
    logic [127:0] o;
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
        b[4*c+r] = sbox(s[127-8*(4*((c+r)%4)+r) -: 8]);
    for (int c = 0; c < 4; c++) begin
      m[4*c] = xt(b[4*c]) ^ xt(b[4*c+1]) ^ b[4*c+1] ^ b[4*c+2] ^ b[4*c+3];
      m[4*c+1] = b[4*c] ^ xt(b[4*c+1]) ^ xt(b[4*c+2]) ^ b[4*c+2]
                 ^ b[4*c+3];
      m[4*c+2] = b[4*c] ^ b[4*c+1] ^ xt(b[4*c+2]) ^ xt(b[4*c+3])
                 ^ b[4*c+3];
      m[4*c+3] = xt(b[4*c]) ^ b[4*c] ^ b[4*c+1] ^ b[4*c+2]
                 ^ xt(b[4*c+3]);
    end
    for (int i = 0; i < 16; i++)
      o[127-8*i -: 8] = fin ? b[i] : m[i];
    aes_round = o ^ k;
  endfunction

  // one AES-128 round per clock, keys expanded on the fly
  assign next_rk = key_step(aes_rk, aes_rc);
  assign next_st = aes_round(aes_st, next_rk, aes_rnd == `STP_AES_ROUNDS);
  assign aes_last = aes_run && (aes_rnd == `STP_AES_ROUNDS);

  // security level byte decode of the telegram's setting
  assign slf_dec.rolling_code_mode_field = tel_slf[`STP_MODE_HI:`STP_MODE_LO];
  assign slf_dec.signature_size_field = tel_slf[`STP_SIZE_HI:`STP_SIZE_LO];
  assign slf_dec.cipher_select_field = tel_slf[`STP_CIPH_HI:`STP_CIPH_LO];

  // teach-in decode; only the first segment carries these fields
  assign ti_first =
    teach_in_info_byte[`STP_TI_IDX_HI:`STP_TI_IDX_LO] == 2'b00;
  assign ti_cnt = ti_first ?
    teach_in_info_byte[`STP_TI_CNT_HI:`STP_TI_CNT_LO] : 2'b00;
  assign ti_psk = ti_first && teach_in_info_byte[`STP_TI_PSK];
  assign ti_switch = ti_first && teach_in_info_byte[`STP_TI_TYPE];
  // low bits mean rocker side for switches, teach-in type otherwise
  assign ti_rocker_b = ti_switch
    && teach_in_info_byte[`STP_TI_INFO_HI:`STP_TI_INFO_LO] == 2'b01;
  assign ti_bidir = ti_first && !teach_in_info_byte[`STP_TI_TYPE]
    && teach_in_info_byte[`STP_TI_INFO_HI:`STP_TI_INFO_LO] == 2'b01;

  function automatic logic slf_ok(input stp_slf_t s);
    logic m;
    logic z;
    logic c;
    m = s.rolling_code_mode_field inside {STP_RLC_NONE, STP_RLC_16_IMPL,
        STP_RLC_24, STP_RLC_32_24, STP_RLC_32};
    z = s.signature_size_field != STP_SIG_RES;
    c = s.cipher_select_field inside {STP_CIPH_PLAIN, STP_CIPH_VARIANT_AES_MODE,
        STP_CIPH_CBC};
    slf_ok = m && z && c;
  endfunction

  // zero-wait apb: read data captured in the setup cycle
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pready = 1'b1;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `STP_SIG_OUT) && (a != 8'h2C);
  endfunction

  always_ff @(posedge clock) begin
    if (srst) begin
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      pslverr <= !mapped(paddr);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      if (paddr == `STP_STATUS) begin
        prdata <= {24'h0, status};
      end else if (paddr == `STP_TEL_SLF) begin
        prdata <= {24'h0, tel_slf};
      end else if (paddr == `STP_TEL_RLC) begin
        prdata <= tel_rlc;
      end else if (paddr == `STP_TEL_SIG) begin
        prdata <= tel_sig;
      end else if (paddr == `STP_TI) begin
        // raw byte plus decoded fields in bits 14:8
        prdata <= {17'h0, ti_cnt, ti_rocker_b, ti_bidir, ti_switch, ti_psk,
                   ti_first, teach_in_info_byte};
      end else if (paddr == `STP_SLF_INFO) begin
        // bit 8 flags one of the common settings
        prdata <= {23'h0, tel_slf inside {`STP_SLF_COMMON_A,
                   `STP_SLF_COMMON_B, `STP_SLF_COMMON_C}, slf_dec};
      end else if (paddr == `STP_ENTRY_SEL) begin
        prdata <= 32'(entry_sel);
      end else if (paddr == `STP_ENTRY_CFG) begin
        prdata <= {23'h0, entry_valid[entry_sel], entry_slf[entry_sel]};
      end else if (paddr == `STP_ENTRY_LRLC) begin
        prdata <= local_tx_rolling_code[entry_sel];
      end else if (paddr == `STP_ENTRY_RRLC) begin
        prdata <= remote_rx_rolling_code[entry_sel];
      end else if (paddr[7:4] == 4'h6) begin
        prdata <= data_out[127-32*paddr[3:2] -: 32];
      end else if (paddr[7:4] == 4'h5) begin
        prdata <= data_in[127-32*paddr[3:2] -: 32];
      end else if (paddr == `STP_SIG_OUT) begin
        prdata <= sig_out;
      end else begin
        // keys are write-only
        prdata <= 32'h0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      entry_sel <= '0;
      tel_slf <= 8'h00;
      tel_rlc <= 32'h0;
      tel_sig <= 32'h0;
      teach_in_info_byte <= 8'h00;
      data_in <= 128'h0;
    end else if (wr_en) begin
      if (paddr == `STP_ENTRY_SEL) entry_sel <= pwdata[IW-1:0];
      if (paddr == `STP_TEL_SLF) tel_slf <= pwdata[7:0];
      if (paddr == `STP_TEL_RLC) tel_rlc <= pwdata;
      if (paddr == `STP_TEL_SIG) tel_sig <= pwdata;
      if (paddr == `STP_TI) teach_in_info_byte <= pwdata[7:0];
      if (paddr[7:4] == 4'h5) data_in[127-32*paddr[3:2] -: 32] <= pwdata;
    end
  end

  // link table slots; hardware updates the rolling codes after a job
  for (genvar g = 0; g < N_DEV; g++) begin : g_link
    logic sel;
    assign sel = wr_en && (entry_sel == IW'(g));
    always_ff @(posedge clock) begin
      if (srst) begin
        key_tx[g] <= 128'h0;
        key_rx[g] <= 128'h0;
        entry_slf[g] <= 8'h00;
        entry_valid[g] <= 1'b0;
      end else if (sel) begin
        if (paddr[7:4] == 4'h3)
          key_tx[g][127-32*paddr[3:2] -: 32] <= pwdata;
        if (paddr[7:4] == 4'h4)
          key_rx[g][127-32*paddr[3:2] -: 32] <= pwdata;
        if (paddr == `STP_ENTRY_CFG) begin
          entry_slf[g] <= pwdata[7:0];
          entry_valid[g] <= pwdata[`STP_ENTRY_VALID_BIT];
        end
      end
    end
    always_ff @(posedge clock) begin
      if (srst) begin
        local_tx_rolling_code[g] <= 32'h0;
        remote_rx_rolling_code[g] <= 32'h0;
      end else if (state == STP_FINISH && job_dev == IW'(g)) begin
        // one step per telegram sent, broadcast included
        if (!job_rx)
          local_tx_rolling_code[g] <= local_tx_rolling_code[g] + 32'h1;
        else if (sig_match)
          remote_rx_rolling_code[g] <= job_rlc;
      end else if (sel && paddr == `STP_ENTRY_LRLC) begin
        local_tx_rolling_code[g] <= pwdata;
      end else if (sel && paddr == `STP_ENTRY_RRLC) begin
        remote_rx_rolling_code[g] <= pwdata;
      end
    end
  end

  assign start_tx = wr_en && paddr == `STP_CTRL && pwdata[`STP_CTRL_TX]
                    && state == STP_IDLE;
  assign start_rx = wr_en && paddr == `STP_CTRL && pwdata[`STP_CTRL_RX]
                    && !pwdata[`STP_CTRL_TX] && state == STP_IDLE;

  // single-block CMAC over plaintext mixed with the rolling code
  assign mac_in = plain ^ {96'h0, job_rlc} ^ subkey;

  // signature is the leading 3 or 4 bytes of the tag
  assign mac_sig = (job_slf.signature_size_field == STP_SIG_24)
                   ? {8'h00, aes_st[127:104]} : aes_st[127:96];
  assign sig_match = (job_slf.signature_size_field == STP_SIG_NONE)
                     || (mac_sig == tel_sig);

  always_ff @(posedge clock) begin
    if (srst) begin
      aes_st <= 128'h0;
      aes_rk <= 128'h0;
      aes_rc <= `STP_RCON_INIT;
      aes_rnd <= 4'h0;
      aes_run <= 1'b0;
    end else if (aes_run && !aes_last) begin
      aes_st <= next_st;
      aes_rk <= next_rk;
      aes_rc <= xt(aes_rc);
      aes_rnd <= aes_rnd + 4'h1;
    end else if (aes_last) begin
      aes_st <= next_st;
      aes_run <= 1'b0;
      // rearm the load, or the next phase would wait forever
      aes_rnd <= 4'h0;
    end else if (state == STP_SUBKEY || state == STP_KSTREAM
                 || state == STP_MAC) begin
      // load a block when the state machine enters a phase
      if (!aes_run && aes_rnd == 4'h0) begin
        aes_st <= job_key ^ ((state == STP_SUBKEY) ? 128'h0 :
                  (state == STP_KSTREAM) ? (IV_BASE ^ {96'h0, job_rlc})
                  : mac_in);
        aes_rk <= job_key;
        aes_rc <= `STP_RCON_INIT;
        aes_rnd <= 4'h1;
        aes_run <= 1'b1;
      end
    end
    if (!aes_run && !(state inside {STP_SUBKEY, STP_KSTREAM, STP_MAC}))
      aes_rnd <= 4'h0;
  end

  // job sequencing; flags stay until the next start
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= STP_IDLE;
      status <= '0;
      job_rx <= 1'b0;
      job_dev <= '0;
      job_key <= 128'h0;
      job_rlc <= 32'h0;
      job_slf <= '0;
      subkey <= 128'h0;
      plain <= 128'h0;
      data_out <= 128'h0;
      sig_out <= 32'h0;
    end else begin
      case (state)
        STP_IDLE: begin
          if (start_tx || start_rx) begin
            status <= '0;
            status.busy <= 1'b1;
            job_rx <= start_rx;
            job_dev <= entry_sel;
            job_slf <= start_rx ? slf_dec : entry_slf[entry_sel];
            job_key <= start_rx ? key_rx[entry_sel] : key_tx[entry_sel];
            job_rlc <= start_rx ? tel_rlc : local_tx_rolling_code[entry_sel];
            plain <= data_in;
            state <= STP_SUBKEY;
            if (start_rx && !entry_valid[entry_sel]) begin
              data_out <= data_in;
              status.passthrough <= 1'b1;
              state <= STP_DONE;
            end else if (start_rx && tel_slf != entry_slf[entry_sel]) begin
              status.slf_mismatch <= 1'b1;
              state <= STP_DONE;
            end else if (start_rx
                         && tel_rlc <= remote_rx_rolling_code[entry_sel]) begin
              status.replay <= 1'b1;
              state <= STP_DONE;
            end else if (!slf_ok(start_rx ? slf_dec : entry_slf[entry_sel])
                         || (start_tx && !entry_valid[entry_sel])) begin
              status.unsupported <= 1'b1;
              state <= STP_DONE;
            end
          end
        end
        STP_SUBKEY: begin
          if (aes_last) begin
            subkey <= {next_st[126:0], 1'b0}
                      ^ {120'h0, next_st[127] ? `STP_CMAC_RB : 8'h00};
            state <= STP_KSTREAM;
          end
        end
        STP_KSTREAM: begin
          if (aes_last) begin
            // variant AES: keystream xor; CBC of one block shares the path
            if (job_slf.cipher_select_field != STP_CIPH_PLAIN) begin
              if (job_rx) plain <= plain ^ next_st;
              else data_out <= plain ^ next_st;
            end else if (!job_rx) begin
              data_out <= plain;
            end
            state <= STP_MAC;
          end
        end
        STP_MAC: begin
          if (aes_last) state <= STP_FINISH;
        end
        STP_FINISH: begin
          if (!job_rx) begin
            sig_out <= (job_slf.signature_size_field == STP_SIG_NONE)
                       ? 32'h0 : mac_sig;
          end else if (sig_match) begin
            data_out <= plain;
            status.auth_ok <= 1'b1;
          end else begin
            data_out <= 128'h0;
            status.auth_fail <= 1'b1;
          end
          state <= STP_DONE;
        end
        STP_DONE: begin
          status.busy <= 1'b0;
          status.done <= 1'b1;
          state <= STP_IDLE;
        end
        default: state <= STP_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

/* verification/stp_engine_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "stp_cfg.svh"

module stp_engine_sva
  import stp_pkg::*;
#(
  parameter int N_DEV = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);

  logic acc, rd_acc, rd_set;
  logic [7:0] slf_sh, ti_sh;
  stp_status_t st;
  assign acc = psel && penable && pready;
  assign rd_acc = acc && !pwrite;
  assign rd_set = psel && !penable && !pwrite;
  assign st = stp_status_t'(prdata[7:0]);

  // shadows follow host writes so decoded reads can be judged
  always_ff @(posedge clock) begin
    if (srst) slf_sh <= 8'h00;
    else if (acc && pwrite && paddr == `STP_TEL_SLF) slf_sh <= pwdata[7:0];
  end
  always_ff @(posedge clock) begin
    if (srst) ti_sh <= 8'h00;
    else if (acc && pwrite && paddr == `STP_TI) ti_sh <= pwdata[7:0];
  end

  property p_slf_mode;
    rd_set && paddr == `STP_SLF_INFO |=> prdata[7:5] == slf_sh[7:5];
  endproperty
  a_slf_mode: assert property (p_slf_mode)
    else $error("mode field decode wrong");
  property p_slf_size;
    rd_acc && paddr == `STP_SLF_INFO |-> prdata[4:3] == slf_sh[4:3];
  endproperty
  a_slf_size: assert property (p_slf_size)
    else $error("size field decode wrong");
  property p_slf_cipher;
    rd_acc && paddr == `STP_SLF_INFO |-> prdata[2:0] == slf_sh[2:0];
  endproperty
  a_slf_cipher: assert property (p_slf_cipher)
    else $error("cipher field decode wrong");
  property p_slf_common;
    rd_acc && paddr == `STP_SLF_INFO |-> prdata[8] == (slf_sh inside
      {`STP_SLF_COMMON_A, `STP_SLF_COMMON_B, `STP_SLF_COMMON_C});
  endproperty
  a_slf_common: assert property (p_slf_common)
    else $error("common value flag wrong");
  property p_ti_raw;
    rd_set && paddr == `STP_TI |=> prdata[7:0] == ti_sh;
  endproperty
  a_ti_raw: assert property (p_ti_raw)
    else $error("teach-in byte altered");
  property p_key_wo;
    rd_acc && paddr >= `STP_KEY_TX && paddr < `STP_DATA_IN |-> prdata == 0;
  endproperty
  a_key_wo: assert property (p_key_wo)
    else $error("key readable");
  property p_auth_excl;
    rd_acc && paddr == `STP_STATUS |-> !(st.auth_ok && st.auth_fail);
  endproperty
  a_auth_excl: assert property (p_auth_excl)
    else $error("auth ok and fail together");
  property p_pass_excl;
    rd_acc && paddr == `STP_STATUS && st.passthrough |->
      !st.auth_ok && !st.auth_fail;
  endproperty
  a_pass_excl: assert property (p_pass_excl)
    else $error("passthrough was processed");
  property p_replay_excl;
    rd_acc && paddr == `STP_STATUS && st.replay |-> !st.auth_ok;
  endproperty
  a_replay_excl: assert property (p_replay_excl)
    else $error("replay accepted");
endmodule

bind stp_engine stp_engine_sva #(.N_DEV(N_DEV)) stp_engine_sva_inst (
  .clock(clock), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

`default_nettype wire

/* verification/stp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "stp_cfg.svh"

module stp_host_model (
  // clock
  input wire logic clock,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep looking valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
  endtask

  // same security byte serves both directions of the entry
  task automatic load_entry(input logic [7:0] idx, input logic [31:0] cfg,
    input logic [127:0] k, input logic [31:0] lr, input logic [31:0] rr);
    wr(`STP_ENTRY_SEL, {24'h0, idx});
    wr(`STP_ENTRY_CFG, cfg);
    for (int i = 0; i < 4; i++) begin
      wr(8'(`STP_KEY_TX + 4 * i), k[127 - 32 * i -: 32]);
      wr(8'(`STP_KEY_RX + 4 * i), k[127 - 32 * i -: 32]);
    end
    wr(`STP_ENTRY_LRLC, lr);
    wr(`STP_ENTRY_RRLC, rr);
  endtask
endmodule

`default_nettype wire

/* verification/test_secure_telegram_processing.sv */
`timescale 1ns/1ps
`default_nettype none
`include "stp_cfg.svh"

module test_secure_telegram_processing;
  typedef struct packed {
    logic [7:0] security_level_byte;
    logic [7:0] ti;
    logic [31:0] info;
    logic [31:0] tinfo;
  } stp_row_t;

  logic clock = 1'b0;
  logic srst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  logic [127:0] ct;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  localparam logic [127:0] KEY = 128'h0011223344556677_8899AABBCCDDEEFF;
  localparam logic [127:0] PT = 128'hCAFE0001_12345678_0F0F0F0F_A5A55A5A;
  stp_row_t rows [6] = '{
    '{8'h4B, 8'h15, 32'h14B, 32'h3515}, '{8'hAB, 8'h09, 32'h1AB, 32'h0B09},
    '{8'hF3, 8'h2C, 32'h1F3, 32'h472C}, '{8'h00, 8'h40, 32'h000, 32'h0040},
    '{8'hE4, 8'hA0, 32'h0E4, 32'h00A0}, '{8'h5B, 8'hFF, 32'h05B, 32'h00FF}};

  always #5 clock = ~clock;

  stp_host_model host_inst (.clock(clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  stp_engine #(.N_DEV(4), .IV_BASE(128'h0)) stp_engine_inst (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s", $time, m);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
    input string m);
    logic [31:0] v;
    host_inst.rd(a, v);
    chk(v, x, m);
  endtask

  task automatic wr128(input logic [7:0] b, input logic [127:0] v);
    for (int i = 0; i < 4; i++)
      host_inst.wr(8'(b + 4 * i), v[127 - 32 * i -: 32]);
  endtask

  task automatic rd128(input logic [7:0] b, output logic [127:0] v);
    for (int i = 0; i < 4; i++)
      host_inst.rd(8'(b + 4 * i), v[127 - 32 * i -: 32]);
  endtask

  // start an operation and poll the done flag with a bounded count
  task automatic runc(input logic [31:0] c, x, input string m);
    logic [31:0] st;
    st = 32'h0;
    host_inst.wr(`STP_CTRL, c);
    for (int i = 0; i < 60 && st[1] !== 1'b1; i++)
      host_inst.rd(`STP_STATUS, st);
    chk(st, x, m);
  endtask

  task automatic rx(input logic [7:0] security_level_byte, input logic [31:0] rc, s,
    input logic [127:0] d, input logic [31:0] x, input string m);
    host_inst.wr(`STP_TEL_SLF, {24'h0, security_level_byte});
    host_inst.wr(`STP_TEL_RLC, rc);
    host_inst.wr(`STP_TEL_SIG, s);
    wr128(`STP_DATA_IN, d);
    runc(32'h2, x, m);
  endtask

  // send through one entry, then feed the result back as a received frame
  task automatic txrx(input logic [7:0] idx, security_level_byte, input logic [31:0] lr);
    logic [31:0] s;
    logic [127:0] pt_got;
    host_inst.load_entry(idx, {23'h0, 1'b1, security_level_byte}, KEY, lr, lr - 1);
    wr128(`STP_DATA_IN, PT);
    runc(32'h1, 32'h02, "tx status");
    rdc(`STP_ENTRY_LRLC, lr + 1, "tx code step");
    rd128(`STP_DATA_OUT, ct);
    chk({31'h0, ct !== PT}, 32'h1, "cipher left plain");
    host_inst.rd(`STP_SIG_OUT, s);
    rx(security_level_byte, lr, s, ct, 32'h06, "rx auth ok");
    rd128(`STP_DATA_OUT, pt_got);
    chk({31'h0, pt_got === PT}, 32'h1, "decrypt");
    rdc(`STP_ENTRY_RRLC, lr, "rx code kept");
    host_inst.wr(`STP_TEL_SIG, s);
  endtask

  initial begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    rdc(`STP_STATUS, 32'h0, "status after reset");
    host_inst.xfer(1'b0, 8'h2C, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped address accepted");
    $display("test reset done");
    foreach (rows[i]) begin
      host_inst.wr(`STP_TEL_SLF, {24'h0, rows[i].security_level_byte});
      host_inst.wr(`STP_TI, {24'h0, rows[i].ti});
      rdc(`STP_SLF_INFO, rows[i].info, "slf decode");
      rdc(`STP_TI, rows[i].tinfo, "teach-in byte");
    end
    $display("test decode done");
    txrx(8'h0, 8'hF3, 32'h5);
    rdc(`STP_KEY_TX, 32'h0, "key readable");
    runc(32'h5, 32'h02, "broadcast tx");
    rdc(`STP_ENTRY_LRLC, 32'h7, "broadcast code step");
    $display("test loop 32 done");
    txrx(8'h1, 8'hAB, 32'hA);
    host_inst.rd(`STP_TEL_SIG, q);
    rx(8'hAB, 32'hA, q, ct, 32'h12, "replay");
    rx(8'hAB, 32'hB, q, ct, 32'h0A, "bad signature");
    rd128(`STP_DATA_OUT, ct);
    chk({31'h0, ct === 128'h0}, 32'h1, "failed data forwarded");
    rdc(`STP_ENTRY_RRLC, 32'hA, "code moved on failure");
    rx(8'hF3, 32'h14, q, ct, 32'h82, "slf mismatch");
    $display("test loop 24 done");
    host_inst.load_entry(8'h2, 32'h100, KEY, 32'h0, 32'h0);
    wr128(`STP_DATA_IN, PT);
    runc(32'h1, 32'h02, "plain tx");
    rd128(`STP_DATA_OUT, ct);
    chk({31'h0, ct === PT}, 32'h1, "plain tx altered");
    rdc(`STP_SIG_OUT, 32'h0, "signature without size");
    host_inst.load_entry(8'h2, 32'h1FB, KEY, 32'h0, 32'h0);
    rx(8'hFB, 32'h9, q, ct, 32'h42, "reserved size");
    host_inst.load_entry(8'h3, 32'h0F3, KEY, 32'h0, 32'h0);
    rx(8'hF3, 32'h9, q, PT, 32'h22, "untaught sender");
    rd128(`STP_DATA_OUT, ct);
    chk({31'h0, ct === PT}, 32'h1, "passthrough changed");
    $display("test rejects done");
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    rdc(`STP_STATUS, 32'h0, "status after second reset");
    rdc(`STP_ENTRY_LRLC, 32'h0, "code after second reset");
    $display("test second reset done");
    stop_test();
  end
endmodule

`default_nettype wire
